// File: hdl/lfs_pkg.sv
// package of constants and types for the led fault status capture block
package lfs_pkg;

    // ************************************************************
    // widths
    // ************************************************************
    localparam int LFS_CHANNELS = 48;    // sink outputs and fault bits
    localparam int LFS_SR_WIDTH = 49;    // common shift register
    localparam int LFS_SEL_BIT = 48;     // msb picks the target latch
    localparam int LFS_BC_WIDTH = 7;     // brightness code per colour
    localparam int LFS_MC_WIDTH = 3;     // maximum current code
    localparam int LFS_EVT_WIDTH = 4;    // interrupt event bits

    // ************************************************************
    // register offsets (byte addresses)
    // ************************************************************
    localparam logic [7:0] LFS_OFS_EVT_STATUS = 8'h00;
    localparam logic [7:0] LFS_OFS_EVT_MASK = 8'h04;
    localparam logic [7:0] LFS_OFS_SETTINGS = 8'h08;
    localparam logic [7:0] LFS_OFS_HOLDER_LO = 8'h0C;
    localparam logic [7:0] LFS_OFS_HOLDER_HI = 8'h10;
    localparam logic [7:0] LFS_OFS_ONOFF_LO = 8'h14;
    localparam logic [7:0] LFS_OFS_ONOFF_HI = 8'h18;
    localparam logic [7:0] LFS_OFS_LINK_STATE = 8'h1C;

    // ************************************************************
    // event bit positions and field values
    // ************************************************************
    localparam int LFS_EVT_ONOFF = 0;    // on-off latch written
    localparam int LFS_EVT_CTRL = 1;     // control latch written
    localparam int LFS_EVT_STLOAD = 2;   // status put in shift reg
    localparam int LFS_EVT_FAULT = 3;    // open or short results captured
    localparam logic [1:0] LFS_SEL_OPEN = 2'h1;
    localparam logic [1:0] LFS_SEL_SHORT = 2'h2;
    localparam logic [6:0] LFS_BC_FULL = 7'h7F;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [3:0] LFS_EVT_RST = 4'h0;
    localparam logic [3:0] LFS_MASK_RST = 4'h0;
    localparam logic [2:0] LFS_MC_RST = 3'h0;
    localparam logic [6:0] LFS_BC_RST = 7'h00;
    localparam logic [1:0] LFS_SEL_RST = 2'h0;
    localparam logic [1:0] LFS_RESP_OKAY = 2'h0;
    localparam logic [1:0] LFS_RESP_SLVERR = 2'h2;

    // control word carried in the low bits of the shift register
    typedef struct packed {
        logic [1:0] load_sel;            // status_load_select
        logic [2:0] max_current;         // max_current_code
        logic [6:0] bc_b;                // blue group_brightness_code
        logic [6:0] bc_g;                // green group_brightness_code
        logic [6:0] bc_r;                // red group_brightness_code
    } lfs_ctrl_t;

    // pins of the serial link, all outside the aclk domain
    typedef struct packed {
        logic sclk;                      // shift clock
        logic sdi;                       // serial_data_in
        logic lat;                       // latch_strobe
        logic blank;                     // blanking, high turns off
    } lfs_link_t;

endpackage : lfs_pkg

// File: hdl/lfs_status_capture.sv
// led fault status capture: serial link, latches, status holder, axi regs
`timescale 1ns/100ps
module lfs_status_capture (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // serial link pins
    input wire lfs_pkg::lfs_link_t link_pins,
    output logic serial_data_out,
    // analog fault comparator results
    input wire logic [lfs_pkg::LFS_CHANNELS-1:0] open_fault_detect,
    input wire logic [lfs_pkg::LFS_CHANNELS-1:0] short_fault_detect,
    // current sink controls
    output logic [lfs_pkg::LFS_CHANNELS-1:0] channel_sink_output,
    output lfs_pkg::lfs_ctrl_t settings,
    output logic [2:0] group_full_scale,
    // interrupt
    output logic irq
);
    import lfs_pkg::*;

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    lfs_link_t link_s1_q;                // first stage, read by s2 only
    lfs_link_t link_s2_q;                // safe to use
    lfs_link_t link_s3_q;                // previous value for edges
    logic [2*LFS_CHANNELS-1:0] fault_s1_q;
    logic [2*LFS_CHANNELS-1:0] fault_s2_q;

    // two flops on every pin; comparators are slow and asynchronous
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link_s1_q <= '0;
            link_s2_q <= '0;
            link_s3_q <= '0;
            fault_s1_q <= '0;
            fault_s2_q <= '0;
        end else begin
            link_s1_q <= link_pins;
            link_s2_q <= link_s1_q;
            link_s3_q <= link_s2_q;
            fault_s1_q <= {short_fault_detect, open_fault_detect};
            fault_s2_q <= fault_s1_q;
        end
    end

    // edge decode of the synchronised pins
    wire sclk_rise = link_s2_q.sclk & ~link_s3_q.sclk;
    wire lat_rise = link_s2_q.lat & ~link_s3_q.lat;
    wire blank_rise = link_s2_q.blank & ~link_s3_q.blank;
    wire [LFS_CHANNELS-1:0] open_s = fault_s2_q[LFS_CHANNELS-1:0];
    wire [LFS_CHANNELS-1:0] short_s =
        fault_s2_q[2*LFS_CHANNELS-1:LFS_CHANNELS];

    // ************************************************************
    // shift register and latches
    // ************************************************************
    logic [LFS_SR_WIDTH-1:0] sr_q;       // common shift register
    logic [LFS_CHANNELS-1:0] onoff_q;    // on-off data latch
    logic [LFS_CHANNELS-1:0] holder_q;   // status_info_word holder
    logic loaded_q;                      // status sits in shift reg
    lfs_ctrl_t ctrl_q;                   // control latch
    logic [2:0] mc_pend_q;               // last max current written
    logic [LFS_CHANNELS-1:0] sink_q;     // registered sink enables
    logic sdo_q;                         // registered serial out

    // which latch an edge writes depends on the msb of the frame
    wire lat_onoff = lat_rise & ~sr_q[LFS_SEL_BIT];
    wire lat_ctrl = lat_rise & sr_q[LFS_SEL_BIT];
    wire [LFS_SR_WIDTH-1:0] sr_shifted = {sr_q[LFS_SR_WIDTH-2:0],
        link_s2_q.sdi};
    wire lfs_ctrl_t ctrl_new = sr_q[$bits(lfs_ctrl_t)-1:0];
    wire status_put = lat_onoff & ~loaded_q;
    wire cap_open = blank_rise & (ctrl_q.load_sel == LFS_SEL_OPEN);
    wire cap_short = blank_rise & (ctrl_q.load_sel == LFS_SEL_SHORT);
    // a disabled channel never reports a fault
    wire [LFS_CHANNELS-1:0] open_masked = open_s & onoff_q;
    wire [LFS_CHANNELS-1:0] short_masked = short_s & onoff_q;

    // latch edges win over a shift edge in the same cycle; the
    // controller never moves both at once so nothing is lost
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sr_q <= '0;
            loaded_q <= 1'b0;
        end else if (status_put) begin
            sr_q[LFS_CHANNELS-1:0] <= holder_q;
            loaded_q <= 1'b1;
        end else if (lat_rise) begin
            sr_q <= sr_q;
        end else if (sclk_rise) begin
            sr_q <= sr_shifted;
            loaded_q <= 1'b0;
        end
    end

    // on-off latch takes the old shift contents before any reload
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            onoff_q <= '0;
        end else if (lat_onoff) begin
            onoff_q <= sr_q[LFS_CHANNELS-1:0];
        end
    end

    // control latch: brightness per colour and load select
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= '{LFS_SEL_RST, LFS_MC_RST, LFS_BC_RST,
                        LFS_BC_RST, LFS_BC_RST};
            mc_pend_q <= LFS_MC_RST;
        end else if (lat_ctrl) begin
            ctrl_q.load_sel <= ctrl_new.load_sel;
            ctrl_q.bc_r <= ctrl_new.bc_r;
            ctrl_q.bc_g <= ctrl_new.bc_g;
            ctrl_q.bc_b <= ctrl_new.bc_b;
            mc_pend_q <= ctrl_new.max_current;
            // current code changes only when written twice alike,
            // so one corrupt frame cannot overdrive the leds
            if (ctrl_new.max_current == mc_pend_q) begin
                ctrl_q.max_current <= ctrl_new.max_current;
            end
        end
    end

    // status holder: open or short results per load select
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            holder_q <= '0;
        end else if (cap_open) begin
            holder_q <= open_masked;
        end else if (cap_short) begin
            holder_q <= short_masked;
        end
    end

    // sink enables gated by the blanking level, serial out from msb
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sink_q <= '0;
            sdo_q <= 1'b0;
        end else begin
            sink_q <= link_s2_q.blank ? '0 : onoff_q;
            sdo_q <= sr_q[LFS_SR_WIDTH-1];
        end
    end

    assign channel_sink_output = sink_q;
    assign serial_data_out = sdo_q;
    assign settings = ctrl_q;
    // full scale marks a code of 7Fh for each colour
    assign group_full_scale = {ctrl_q.bc_b == LFS_BC_FULL,
                               ctrl_q.bc_g == LFS_BC_FULL,
                               ctrl_q.bc_r == LFS_BC_FULL};

    // ************************************************************
    // axi4-lite slave
    // ************************************************************
    logic aw_have_q;                     // address held
    logic w_have_q;                      // data held
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic [3:0] evt_q;                   // sticky events
    logic [3:0] mask_q;                  // interrupt mask

    // expand byte strobes into a bit mask
    function automatic logic [31:0] lfs_strb_bits(input logic [3:0] s);
        lfs_strb_bits = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    assign s_axi_awready = ~aw_have_q & ~bvalid_q;
    assign s_axi_wready = ~w_have_q & ~bvalid_q;
    assign s_axi_arready = ~rvalid_q;
    wire wr_go = aw_have_q & w_have_q & ~bvalid_q;
    wire [31:0] wr_bits = wdata_q & lfs_strb_bits(wstrb_q);
    wire wr_status = wr_go & (awaddr_q == LFS_OFS_EVT_STATUS);
    wire wr_mask = wr_go & (awaddr_q == LFS_OFS_EVT_MASK);
    wire wr_ok = wr_status | wr_mask;

    // read decode; unmapped words answer zero with slverr
    wire [7:0] ra = s_axi_araddr;
    wire rd_ok = (ra <= LFS_OFS_LINK_STATE) & (ra[1:0] == 2'b00);
    wire [31:0] rd_mux =
        (ra == LFS_OFS_EVT_STATUS) ? {28'h000_0000, evt_q} :
        (ra == LFS_OFS_EVT_MASK) ? {28'h000_0000, mask_q} :
        (ra == LFS_OFS_SETTINGS) ? {3'h0, mc_pend_q, ctrl_q} :
        (ra == LFS_OFS_HOLDER_LO) ? holder_q[31:0] :
        (ra == LFS_OFS_HOLDER_HI) ? {16'h0000, holder_q[47:32]} :
        (ra == LFS_OFS_ONOFF_LO) ? onoff_q[31:0] :
        (ra == LFS_OFS_ONOFF_HI) ? {16'h0000, onoff_q[47:32]} :
        (ra == LFS_OFS_LINK_STATE) ?
            {30'h0000_0000, loaded_q, sr_q[LFS_SEL_BIT]} : 32'h0000_0000;

    // write channels taken in either order, answered after both
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= LFS_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_ok ? LFS_RESP_OKAY : LFS_RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // read answered one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= LFS_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= rd_ok ? LFS_RESP_OKAY : LFS_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // ************************************************************
    // interrupt status and mask
    // ************************************************************
    wire [3:0] evt_set = {cap_open | cap_short, status_put,
                          lat_ctrl, lat_onoff};
    wire [3:0] evt_clr = wr_status ? wr_bits[3:0] : 4'h0;

    // a new event in the clearing cycle survives: set beats clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evt_q <= LFS_EVT_RST;
            mask_q <= LFS_MASK_RST;
        end else begin
            evt_q <= (evt_q & ~evt_clr) | evt_set;
            // an unstrobed byte lane keeps its old mask bits
            if (wr_mask && wstrb_q[0]) begin
                mask_q <= wdata_q[3:0];
            end
        end
    end

    assign irq = |(evt_q & mask_q);

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_onoff_latch;
        lat_onoff ##0 !loaded_q;
    endsequence

    sequence s_shift_only;
        sclk_rise && !lat_rise;
    endsequence

    AST_STATUS_LOAD: assert property (
        s_onoff_latch |=> sr_q[47:0] == $past(holder_q) && loaded_q)
        else $error("status not loaded on on-off latch edge");
    AST_ONOFF_COPY: assert property (
        lat_onoff |=> onoff_q == $past(sr_q[47:0]))
        else $error("on-off latch did not take old shift data");
    AST_CTRL_KEEP: assert property (
        lat_ctrl |=> sr_q == $past(sr_q))
        else $error("control latch edge disturbed shift register");
    AST_NO_RELOAD: assert property (
        lat_onoff && loaded_q |=> sr_q == $past(sr_q) && loaded_q)
        else $error("status reloaded before new serial data");
    AST_FLAG_CLEAR: assert property (
        s_shift_only |=> !loaded_q ##0 sr_q[0] == $past(link_s2_q.sdi))
        else $error("shift did not clear status flag");
    AST_OPEN_CAPTURE: assert property (
        cap_open |=> holder_q == $past(open_s & onoff_q))
        else $error("open results not captured");
    AST_SHORT_CAPTURE: assert property (
        cap_short |=> holder_q == $past(short_s & onoff_q))
        else $error("short results not captured");
    AST_BLANK_GATE: assert property (
        link_s2_q.blank |=> channel_sink_output == '0)
        else $error("output on while blanked");
    AST_FULL_SCALE: assert property (
        ##1 group_full_scale[0] == ($past(ctrl_q.bc_r) == LFS_BC_FULL)
            || $past(lat_ctrl))
        else $error("full-scale flag wrong for red code");
    AST_MC_TWICE: assert property (
        lat_ctrl && ctrl_new.max_current != mc_pend_q
        |=> ctrl_q.max_current == $past(ctrl_q.max_current))
        else $error("current code changed on single write");

endmodule // lfs_status_capture

// File: verif/lfs_link_ctrl.sv
// display controller model that drives the serial link pins
`timescale 1ns/100ps
module lfs_link_ctrl (
    // bench clock, used only to realign after each action
    input wire logic aclk,
    // serial link towards the block
    output lfs_pkg::lfs_link_t link_pins,
    input wire logic serial_data_out
);
    import lfs_pkg::*;

    // all pins start low; shift clock stands still between frames
    initial begin
        link_pins = '0;
    end

    // *****************************************************
    // frame: 49 bits msb first, 125 ns shift clock
    // *****************************************************
    task automatic send_frame(input logic [48:0] w,
                              output logic [48:0] seen);
        for (int i = 48; i >= 0; i--) begin
            link_pins.sdi = w[i];
            #62.5;
            // sample just before the rise, after last shift settled
            seen[i] = serial_data_out;
            link_pins.sclk = 1'b1;
            #62.5;
            link_pins.sclk = 1'b0;
        end
        // no pull on the data line: show the inverse once released
        link_pins.sdi = ~w[0];
        @(posedge aclk);
    endtask

    // latch pulse held far longer than three sampling cycles
    task automatic pulse_lat();
        #30 link_pins.lat = 1'b1;
        #100 link_pins.lat = 1'b0;
        #200;
        @(posedge aclk);
    endtask

    // blanking level; a rise only after outputs ran at least 1 us
    task automatic set_blank(input logic lvl);
        if (lvl) #1000;
        link_pins.blank = lvl;
        #200;
        @(posedge aclk);
    endtask
endmodule // lfs_link_ctrl

// File: verif/lfs_status_capture_bench.sv
// self-checking bench for the led fault status capture block
`timescale 1ns/100ps
module lfs_status_capture_bench;
    import lfs_pkg::*;

    // *****************************************************
    // signals and reference model state
    // *****************************************************
    logic aclk, aresetn;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [1:0] bresp, rresp;
    lfs_link_t pins;
    logic sdo, irq;
    logic [47:0] openf, shortf, chan;
    lfs_ctrl_t settings;
    logic [2:0] gfs;
    logic [48:0] m_sr;
    logic [47:0] m_onoff, m_holder;
    logic [25:0] m_set;
    logic [2:0] m_pend;
    logic [3:0] m_evt, m_mask;
    logic m_flag;
    int num_errors, total_checks;

    lfs_status_capture i_lfs_status_capture (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .link_pins(pins),
        .serial_data_out(sdo), .open_fault_detect(openf),
        .short_fault_detect(shortf), .channel_sink_output(chan),
        .settings(settings), .group_full_scale(gfs), .irq(irq));

    lfs_link_ctrl i_lfs_link_ctrl (
        .aclk(aclk), .link_pins(pins), .serial_data_out(sdo));

    // 100 MHz clock
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [63:0] e,
                       input logic [63:0] g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    // a bus wait that ran out ends the run
    task automatic hang(input logic t_out);
        if (t_out) begin
            num_errors++;
            $display("Error bus answer expected 1 seen 0");
            wrap_up();
        end
    endtask

    // *****************************************************
    // axi4-lite master tasks
    // *****************************************************
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 100);
        bready <= 1'b0;
        hang(!bvalid);
        chk("bresp", er, bresp);
        // idle edge so a following call never re-drives bready now
        @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 100);
        rready <= 1'b0;
        hang(!rvalid);
        chk($sformatf("reg %h", a), e, rdata);
        chk("rresp", er, rresp);
        // idle edge so a following call never re-drives rready now
        @(posedge aclk);
    endtask

    // compare sinks, settings, irq and the link, settings, holder and on-off registers against the model
    task automatic state();
        chk("sinks", m_onoff, chan);
        chk("settings", m_set, settings);
        chk("full scale", {m_set[20:14] == LFS_BC_FULL,
            m_set[13:7] == LFS_BC_FULL,
            m_set[6:0] == LFS_BC_FULL}, gfs);
        chk("irq", |(m_evt & m_mask), irq);
        rd(LFS_OFS_LINK_STATE, {30'h0, m_flag, m_sr[48]}, 2'h0);
        rd(LFS_OFS_SETTINGS, {3'h0, m_pend, m_set}, 2'h0);
        rd(LFS_OFS_HOLDER_LO, m_holder[31:0], 2'h0);
        rd(LFS_OFS_HOLDER_HI, {16'h0, m_holder[47:32]}, 2'h0);
        rd(LFS_OFS_ONOFF_LO, m_onoff[31:0], 2'h0);
        rd(LFS_OFS_ONOFF_HI, {16'h0, m_onoff[47:32]}, 2'h0);
    endtask

    // latch edge: on-off copy then status load, or control update
    task automatic latch();
        i_lfs_link_ctrl.pulse_lat();
        if (!m_sr[48]) begin
            m_onoff = m_sr[47:0];
            m_evt[LFS_EVT_ONOFF] = 1'b1;
            // status only once per fresh shift
            if (!m_flag) begin
                m_sr[47:0] = m_holder;
                m_flag = 1'b1;
                m_evt[LFS_EVT_STLOAD] = 1'b1;
            end
        end else begin
            m_evt[LFS_EVT_CTRL] = 1'b1;
            m_set = {m_sr[25:24], m_set[23:21], m_sr[20:0]};
            // current code takes effect on a repeated value only
            if (m_sr[23:21] == m_pend) m_set[23:21] = m_pend;
            m_pend = m_sr[23:21];
        end
        state();
    endtask

    task automatic frame(input logic [48:0] w);
        logic [48:0] seen;
        i_lfs_link_ctrl.send_frame(w, seen);
        chk("serial out", m_sr, seen);
        m_sr = w;
        m_flag = 1'b0;
        latch();
    endtask

    task automatic blank_pulse();
        i_lfs_link_ctrl.set_blank(1'b1);
        chk("sinks blanked", 48'h0, chan);
        if (m_set[25:24] == LFS_SEL_OPEN) m_holder = openf & m_onoff;
        if (m_set[25:24] == LFS_SEL_SHORT) m_holder = shortf & m_onoff;
        if (m_set[25:24] inside {LFS_SEL_OPEN, LFS_SEL_SHORT})
            m_evt[LFS_EVT_FAULT] = 1'b1;
        i_lfs_link_ctrl.set_blank(1'b0);
        state();
    endtask

    // *****************************************************
    // main sequence
    // *****************************************************
    initial begin
        lfs_ctrl_t c;
        logic [47:0] oo;
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        {openf, shortf} = '0;
        {m_sr, m_onoff, m_holder, m_set, m_pend} = '0;
        {m_evt, m_mask, m_flag} = '0;
        void'($urandom(15));
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        for (int a = 0; a < 32; a += 4) rd(8'(a), 32'h0, 2'h0);
        state();
        rd(8'h20, 32'h0, LFS_RESP_SLVERR);
        rd(8'h06, 32'h0, LFS_RESP_SLVERR);
        wr(8'h24, 32'hFFFF_FFFF, LFS_RESP_SLVERR);
        // load selects: none, open, short
        for (int s = 0; s < 3; s++) begin
            c.load_sel = s[1:0];
            c.max_current = 3'($urandom);
            c.bc_r = (s == 0) ? LFS_BC_FULL : 7'($urandom);
            c.bc_g = (s == 1) ? LFS_BC_FULL : 7'($urandom);
            c.bc_b = (s == 2) ? LFS_BC_FULL : 7'($urandom);
            m_mask = 4'($urandom);
            wr(LFS_OFS_EVT_MASK, {28'h0, m_mask}, 2'h0);
            rd(LFS_OFS_EVT_MASK, {28'h0, m_mask}, 2'h0);
            // byte 0 not strobed: the mask must keep its value
            wstrb <= 4'hE;
            wr(LFS_OFS_EVT_MASK, 32'h0000_000F, 2'h0);
            wstrb <= 4'hF;
            rd(LFS_OFS_EVT_MASK, {28'h0, m_mask}, 2'h0);
            repeat (2) frame({1'b1, 22'h0, c});
            oo = {16'($urandom), 32'($urandom)};
            frame({1'b0, oo});
            openf <= {16'($urandom), 32'($urandom)};
            shortf <= {16'($urandom), 32'($urandom)};
            @(posedge aclk);
            blank_pulse();
            latch();
            frame({1'b0, oo});
            rd(LFS_OFS_EVT_STATUS, {28'h0, m_evt}, 2'h0);
            wr(LFS_OFS_EVT_STATUS, {28'h0, m_evt}, 2'h0);
            m_evt = 4'h0;
            rd(LFS_OFS_EVT_STATUS, 32'h0, 2'h0);
            state();
        end
        frame({1'b1, 48'h0});
        wrap_up();
    end
endmodule // lfs_status_capture_bench
